// file: shared/madp_pkg.sv
// constants and types shared by the address/data pin control block
package madp_pkg;

  // ***************************************************************
  // field positions and widths
  // ***************************************************************
  localparam int unsigned FLAG_SEL_BIT  = 20;
  localparam int unsigned PIN_W         = 16;
  localparam int unsigned ADDR_W        = 24;

  // ***************************************************************
  // timing counts in core clocks
  // ***************************************************************
  localparam logic [3:0]  ADDR_CYC_RST  = 4'h2;
  localparam logic [3:0]  DATA_CYC_RST  = 4'h4;

  // ***************************************************************
  // reset values
  // ***************************************************************
  localparam logic [15:0] PIN_OUT_RST   = 16'h0000;
  localparam logic [15:0] PIN_OE_RST    = 16'h0000;

  typedef enum logic {MADP_W8, MADP_W16} madp_width_t;

  typedef enum {MADP_IDLE, MADP_ADDR, MADP_DATA, MADP_DONE} madp_state_t;

endpackage

// file: shared/madp_lane_if.sv
// lane drive bundle passed from the sequencer to the lane mapper
`timescale 1ns/1ns
`default_nettype none
interface madp_lane_if;
  logic        addrPhase;
  logic        wide;
  logic [23:0] addr;
  logic [15:0] wrData;
  logic [15:0] laneOut;

  modport seq (output addrPhase, output wide, output addr, output wrData, input laneOut);
  modport map (input addrPhase, input wide, input addr, input wrData, output laneOut);
endinterface
`default_nettype wire

// file: hdl/madp_lane_map.sv
// lane placement of address and data on the shared pins
`timescale 1ns/1ns
`default_nettype none
module madp_lane_map
  import madp_pkg::*;
(
  // lane bundle
  madp_lane_if.map lane
);

  always_comb
  begin
    if (lane.wide)
    begin
      if (lane.addrPhase)
        lane.laneOut = {lane.addr[15:8], lane.addr[7:0]};
      else
        lane.laneOut = {lane.wrData[15:8], lane.wrData[7:0]};
    end
    else
    begin
      if (lane.addrPhase)
        lane.laneOut = {lane.addr[23:16], lane.addr[15:8]};
      else
        lane.laneOut = {lane.addr[7:0], lane.wrData[7:0]};
    end
  end

endmodule
`default_nettype wire

// file: hdl/madp_pin_ctrl.sv
// shared address/data pin control: parallel port sequencer and flag mux
`timescale 1ns/1ns
`default_nettype none
module madp_pin_ctrl
  import madp_pkg::*;
#(
  parameter logic [3:0] ADDR_CYC = ADDR_CYC_RST,
  parameter logic [3:0] DATA_CYC = DATA_CYC_RST
)
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        arst_n,
  // configuration
  input  wire logic [31:0] system_config_reg,
  input  wire logic        portEnable,
  input  wire logic        port_width_mode,
  // transfer request
  input  wire logic        reqValid,
  input  wire logic        reqWrite,
  input  wire logic [23:0] reqAddr,
  input  wire logic [15:0] reqWrData,
  output logic             reqDone,
  output logic [15:0]      rdData,
  // flags on the core side
  input  wire logic [15:0] flagOut,
  input  wire logic [15:0] flagOutEn,
  output logic [15:0]      flagIn,
  // shared pins
  input  wire logic [15:0] shared_bus_pins_i,
  output logic [15:0]      shared_bus_pins_o,
  output logic [15:0]      shared_bus_pins_oe,
  // strobes
  output logic             latchStrobe,
  output logic             readStrobe_n,
  output logic             writeStrobe_n
);

  // ***************************************************************
  // lane mapper
  // ***************************************************************
  madp_lane_if lane();

  madp_lane_map uMap
  (
    .lane (lane)
  );

  // ***************************************************************
  // state
  // ***************************************************************
  madp_state_t state_q, state_d;
  logic [3:0]  cnt_q, cnt_d;
  logic        write_q, write_d;
  logic        wide_q, wide_d;
  logic [23:0] addr_q, addr_d;
  logic [15:0] wdat_q, wdat_d;
  logic [15:0] rd_q, rd_d;
  logic        done_q, done_d;
  logic [15:0] pinO_q, pinO_d;
  logic [15:0] pinOe_q, pinOe_d;
  logic        ale_q, ale_d;
  logic        rdn_q, rdn_d;
  logic        wrn_q, wrn_d;
  logic [15:0] flagIn_q, flagIn_d;
  logic        flagMode;
  logic        takeReq;

  // swap byte halves between pin and flag numbering
  function automatic logic [15:0] swapHalves(input logic [15:0] v);
    swapHalves = {v[7:0], v[15:8]};
  endfunction

  // pins still driven in the data phase; an 8-bit read keeps the address lane
  function automatic logic [15:0] dataOe(input logic wr, input logic w16);
    dataOe = wr ? 16'hFFFF : (w16 ? 16'h0000 : 16'hFF00);
  endfunction

  // ***************************************************************
  // configuration decode
  // ***************************************************************
  assign flagMode        = system_config_reg[FLAG_SEL_BIT] & ~portEnable;
  // a request still up while done pulses belongs to the transfer ending now
  assign takeReq         = portEnable & reqValid & ~done_q;
  assign lane.addrPhase  = (state_q == MADP_ADDR);
  assign lane.wide       = wide_q;
  assign lane.addr       = addr_q;
  assign lane.wrData     = wdat_q;

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb
  begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    write_d  = write_q;
    wide_d   = wide_q;
    addr_d   = addr_q;
    wdat_d   = wdat_q;
    rd_d     = rd_q;
    done_d   = 1'b0;
    ale_d    = 1'b0;
    rdn_d    = 1'b1;
    wrn_d    = 1'b1;
    pinO_d   = PIN_OUT_RST;
    pinOe_d  = PIN_OE_RST;
    flagIn_d = swapHalves(shared_bus_pins_i);
    case (state_q)
      MADP_IDLE:
      begin
        if (flagMode)
        begin
          pinO_d  = swapHalves(flagOut);
          pinOe_d = swapHalves(flagOutEn);
        end
        else if (takeReq)
        begin
          // address always goes first, so latch is raised before any strobe
          state_d = MADP_ADDR;
          cnt_d   = ADDR_CYC;
          write_d = reqWrite;
          wide_d  = (port_width_mode == MADP_W16);
          addr_d  = reqAddr;
          wdat_d  = reqWrData;
        end
      end
      MADP_ADDR:
      begin
        ale_d   = 1'b1;
        pinO_d  = lane.laneOut;
        pinOe_d = 16'hFFFF;
        cnt_d   = cnt_q - 4'h1;
        if (cnt_q == 4'h1)
        begin
          state_d = MADP_DATA;
          cnt_d   = DATA_CYC;
        end
      end
      MADP_DATA:
      begin
        pinO_d  = lane.laneOut;
        // 8-bit: high lane keeps address, only low lane turns for reads
        pinOe_d = dataOe(write_q, wide_q);
        rdn_d   = write_q;
        wrn_d   = ~write_q;
        cnt_d   = cnt_q - 4'h1;
        if (cnt_q == 4'h1)
        begin
          state_d = MADP_DONE;
          if (!write_q)
            rd_d = wide_q ? shared_bus_pins_i : {8'h00, shared_bus_pins_i[7:0]};
        end
      end
      MADP_DONE:
      begin
        done_d  = 1'b1;
        state_d = MADP_IDLE;
      end
      default:
      begin
        state_d = MADP_IDLE;
      end
    endcase
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q  <= MADP_IDLE;
      cnt_q    <= 4'h0;
      write_q  <= 1'b0;
      wide_q   <= 1'b0;
      addr_q   <= 24'h000000;
      wdat_q   <= 16'h0000;
      rd_q     <= 16'h0000;
      done_q   <= 1'b0;
      pinO_q   <= PIN_OUT_RST;
      pinOe_q  <= PIN_OE_RST;
      ale_q    <= 1'b0;
      rdn_q    <= 1'b1;
      wrn_q    <= 1'b1;
      flagIn_q <= 16'h0000;
    end
    else
    begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      write_q  <= write_d;
      wide_q   <= wide_d;
      addr_q   <= addr_d;
      wdat_q   <= wdat_d;
      rd_q     <= rd_d;
      done_q   <= done_d;
      pinO_q   <= pinO_d;
      pinOe_q  <= pinOe_d;
      ale_q    <= ale_d;
      rdn_q    <= rdn_d;
      wrn_q    <= wrn_d;
      flagIn_q <= flagIn_d;
    end
  end

  // ***************************************************************
  // outputs
  // ***************************************************************
  // strobes have no enable: always driven
  assign latchStrobe        = ale_q;
  assign readStrobe_n       = rdn_q;
  assign writeStrobe_n      = wrn_q;
  assign shared_bus_pins_o  = pinO_q;
  assign shared_bus_pins_oe = pinOe_q;
  assign reqDone            = done_q;
  assign rdData             = rd_q;
  assign flagIn             = flagIn_q;

endmodule
`default_nettype wire

// file: dv/madp_mem_model.sv
// external address latch and asynchronous memory on the shared pins
`timescale 1ns/1ns
`default_nettype none
module madp_mem_model
(
  // strobes and mode
  input  wire logic        clk,
  input  wire logic        latchStrobe,
  input  wire logic        readStrobe_n,
  input  wire logic        writeStrobe_n,
  input  wire logic        wide,
  // pins
  input  wire logic [15:0] pinLevel,
  output logic      [15:0] memOut,
  output logic      [15:0] memOe
);
  // ***************
  // latch and array
  // ***************
  logic [23:0] addrQ;
  logic [7:0]  ix;
  logic [15:0] mem [0:255];
  // sampled mid-cycle, so a strobe edge and a lane change never race
  always @(negedge clk)
    if (latchStrobe)
      addrQ <= wide ? {8'h00, pinLevel} : {pinLevel, 8'h00};
  assign ix = wide ? addrQ[7:0] : pinLevel[15:8];
  always @(negedge clk)
    if (!writeStrobe_n)
      mem[ix] <= wide ? pinLevel : {8'h00, pinLevel[7:0]};
  assign memOut = mem[ix];
  assign memOe = readStrobe_n ? 16'h0000 : (wide ? 16'hFFFF : 16'h00FF);
endmodule
`default_nettype wire

// file: dv/madp_pin_ctrl_sva.sv
// assertions on the pin control ports
`timescale 1ns/1ns
`default_nettype none
module madp_pin_ctrl_sva
  import madp_pkg::*;
#(
  parameter logic [3:0] ADDR_CYC = ADDR_CYC_RST,
  parameter logic [3:0] DATA_CYC = DATA_CYC_RST
)
(
  // inputs
  input wire logic        sys_clk,
  input wire logic        arst_n,
  input wire logic [31:0] system_config_reg,
  input wire logic        portEnable,
  input wire logic        port_width_mode,
  input wire logic [23:0] reqAddr,
  input wire logic [15:0] reqWrData,
  input wire logic [15:0] flagOut,
  // outputs
  input wire logic        reqDone,
  input wire logic [15:0] shared_bus_pins_o,
  input wire logic        latchStrobe,
  input wire logic        readStrobe_n,
  input wire logic        writeStrobe_n
);
  // ***********
  // port checks
  // ***********
  localparam int Span = ADDR_CYC + DATA_CYC;
  logic        fm;
  logic        w;
  logic [15:0] flagSw;
  assign fm = system_config_reg[FLAG_SEL_BIT] & ~portEnable;
  assign w = port_width_mode;
  // expected flag drive in pin numbering
  assign flagSw = {flagOut[7:0], flagOut[15:8]};
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  a_strobe_excl: assert property (readStrobe_n || writeStrobe_n)
    else $error("both strobes low");
  a_latch_narrow: assert property (
    latchStrobe && !w |-> shared_bus_pins_o == reqAddr[23:8])
    else $error("latch lanes 8-bit");
  a_latch_wide: assert property (
    latchStrobe && w |-> shared_bus_pins_o == reqAddr[15:0])
    else $error("latch lanes 16-bit");
  a_data_narrow: assert property (
    !writeStrobe_n && !w |-> shared_bus_pins_o == {reqAddr[7:0], reqWrData[7:0]})
    else $error("data lanes 8-bit");
  a_data_wide: assert property (
    !writeStrobe_n && w |-> shared_bus_pins_o == reqWrData)
    else $error("data lanes 16-bit");
  a_flag_swap: assert property (
    $past(arst_n) && $past(fm) && fm |-> shared_bus_pins_o == $past(flagSw))
    else $error("flag map");
  a_addr_first: assert property (
    $fell(readStrobe_n && writeStrobe_n) |-> $past(latchStrobe))
    else $error("data before address");
  a_done_time: assert property ($rose(latchStrobe) |-> ##Span reqDone ##1 !reqDone)
    else $error("done timing");
endmodule
bind madp_pin_ctrl madp_pin_ctrl_sva #(.ADDR_CYC(ADDR_CYC), .DATA_CYC(DATA_CYC)) u_sva (.*);
`default_nettype wire

// file: dv/muxed_addr_data_pin_control_tb.sv
// self-checking bench for the shared pin control block
`timescale 1ns/1ns
`default_nettype none
module muxed_addr_data_pin_control_tb
  import madp_pkg::*;
;
  // *******
  // harness
  // *******
  logic        sys_clk = 1'b0, arst_n = 1'b0, portEnable = 1'b1, port_width_mode = 1'b0;
  logic        reqValid = 1'b0, reqWrite = 1'b0, reqDone, latchStrobe, readStrobe_n;
  logic        writeStrobe_n;
  logic [31:0] system_config_reg = 32'h00000000;
  logic [23:0] reqAddr = 24'h000000;
  logic [15:0] reqWrData = 16'h0000, flagOut = 16'h0000, flagOutEn = 16'h0000;
  logic [15:0] extV = 16'h0000, extE = 16'h0000, rdData, flagIn, memOut, memOe;
  logic [15:0] shared_bus_pins_i, shared_bus_pins_o, shared_bus_pins_oe;
  int          fails = 0, n_tests = 0;
  // undriven pin bits float up to the pull-up level
  assign shared_bus_pins_i = (shared_bus_pins_oe & shared_bus_pins_o)
    | (~shared_bus_pins_oe & memOe & memOut) | (~shared_bus_pins_oe & ~memOe & (~extE | extV));
  always #2 sys_clk = ~sys_clk;
  madp_pin_ctrl dut (.*);
  madp_mem_model mem (.clk(sys_clk), .latchStrobe(latchStrobe), .readStrobe_n(readStrobe_n),
    .writeStrobe_n(writeStrobe_n), .wide(port_width_mode), .pinLevel(shared_bus_pins_i),
    .memOut(memOut), .memOe(memOe));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // request held until the done pulse, dropped on the next edge
  task automatic xfer(input logic w16, input logic wr, input logic [23:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    port_width_mode <= w16;
    reqWrite <= wr;
    reqAddr <= a;
    reqWrData <= d;
    reqValid <= 1'b1;
    repeat (40)
    begin
      @(negedge sys_clk);
      if (reqDone === 1'b1)
        break;
    end
    chk("done", 16'h0001, {15'h0000, reqDone});
    @(posedge sys_clk);
    reqValid <= 1'b0;
  endtask
  task automatic settle(input logic [31:0] cfg, input logic en);
    @(posedge sys_clk);
    system_config_reg <= cfg;
    portEnable <= en;
    repeat (3) @(negedge sys_clk);
  endtask
  task automatic sc_port8;
    xfer(1'b0, 1'b1, 24'hABCD12, 16'h5577);
    xfer(1'b0, 1'b1, 24'h000013, 16'h0088);
    xfer(1'b0, 1'b0, 24'hABCD12, 16'h0000);
    chk("rd8", 16'h0077, rdData);
    chk("strobes", 16'h0003, {14'h0000, readStrobe_n, writeStrobe_n});
  endtask
  task automatic sc_port16;
    xfer(1'b1, 1'b1, 24'hFFFF34, 16'hBEEF);
    xfer(1'b1, 1'b1, 24'h000035, 16'h1234);
    xfer(1'b1, 1'b0, 24'hFFFF34, 16'h0000);
    chk("rd16", 16'hBEEF, rdData);
  endtask
  task automatic sc_flags;
    flagOut <= 16'h12A5;
    flagOutEn <= 16'hFFFF;
    settle(32'h00100000, 1'b0);
    chk("flagpins", 16'hA512, shared_bus_pins_o);
    chk("flagoe", 16'hFFFF, shared_bus_pins_oe);
    @(posedge sys_clk);
    flagOutEn <= 16'h0000;
    extE <= 16'hFFFF;
    extV <= 16'h3C81;
    repeat (3) @(negedge sys_clk);
    chk("flagin", 16'h813C, flagIn);
    // enables back up, so a port that kept flag use would show on the pins
    @(posedge sys_clk);
    extE <= 16'h0000;
    flagOutEn <= 16'hFFFF;
    settle(32'h00100000, 1'b1);
    chk("portoe", 16'h0000, shared_bus_pins_oe);
    xfer(1'b1, 1'b0, 24'h000035, 16'h0000);
    chk("rdport", 16'h1234, rdData);
    settle(32'h00000000, 1'b0);
    chk("nosel", 16'h0000, shared_bus_pins_oe);
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    #20000;
    fails++;
    report_and_stop();
  end
  initial
  begin
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(negedge sys_clk);
    chk("rstoe", PIN_OE_RST, shared_bus_pins_oe);
    sc_port8();
    sc_port16();
    sc_flags();
    report_and_stop();
  end
endmodule
`default_nettype wire
